// ---- bench/cpu_stack_and_interrupt_control_bench.sv ----
`default_nettype none
module cpu_stack_and_interrupt_control_bench
  import csic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  io_addr = 6'h00;
  logic        io_wr = 1'b0;
  logic [7:0]  io_wdata = 8'h00;
  csic_op_t    op_in = OP_NONE;
  logic [7:0]  push_data = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic        ins_end = 1'b0;
  logic        sleep = 1'b0;
  logic        gie_set = 1'b0;
  logic        gie_clr = 1'b0;
  logic        st_wr = 1'b0;
  logic [7:0]  st_wdata = 8'h00;
  logic [7:0]  ev = 8'h00;
  logic [7:0]  lvl = 8'h00;
  logic [7:0]  ena = 8'h00;
  logic [7:0]  w1c = 8'h00;
  logic        alu_v = 1'b0;
  csic_alu_t   alu_op = ALU_ADD;
  logic [7:0]  alu_a = 8'h00;
  logic [7:0]  alu_b = 8'h00;
  logic [7:0]  io_rdata, st_wdat, st_rdata, flags, ack, alu_res;
  logic [15:0] st_addr, sp, pc_tgt;
  logic        st_we, st_re, gie, pc_load, busy, alu_done, fetch_en;
  logic [15:0] pc_q [$];
  logic [7:0]  alu_q [$];
  int          err_count = 0;
  int          samples_checked = 0;

  always #5 mclk = ~mclk;

  csic_core #(.NUM_SRC(8), .SP_WIDTH(16), .LEVEL_MASK(8'h80)) csic_core_i
  (
    .MCLK_IN(mclk), .RST_IN(rst), .IO_ADDR_IN(io_addr), .IO_WR_IN(io_wr),
    .IO_WDATA_IN(io_wdata), .IO_RDATA_OUT(io_rdata), .OP_IN(op_in),
    .PUSH_DATA_IN(push_data), .PC_IN(pc_in), .INSTR_END_IN(ins_end),
    .SLEEP_IN(sleep), .GIE_SET_IN(gie_set), .GIE_CLR_IN(gie_clr),
    .STATUS_WR_IN(st_wr), .STATUS_WDATA_IN(st_wdata), .IRQ_EVENT_IN(ev),
    .IRQ_LEVEL_IN(lvl), .IRQ_ENABLE_IN(ena), .IRQ_FLAG_CLR_IN(w1c),
    .ALU_VALID_IN(alu_v), .ALU_OP_IN(alu_op), .ALU_A_IN(alu_a), .ALU_B_IN(alu_b),
    .STACK_RDATA_IN(st_rdata), .STACK_ADDR_OUT(st_addr), .STACK_WDATA_OUT(st_wdat),
    .STACK_WE_OUT(st_we), .STACK_RE_OUT(st_re), .SP_OUT(sp), .GIE_OUT(gie),
    .IRQ_FLAGS_OUT(flags), .IRQ_ACK_OUT(ack), .PC_LOAD_OUT(pc_load),
    .PC_TARGET_OUT(pc_tgt), .BUSY_OUT(busy), .FETCH_EN_OUT(fetch_en), .ALU_RESULT_OUT(alu_res),
    .ALU_DONE_OUT(alu_done)
  );

  csic_stack_mem csic_stack_mem_i
  (
    .clk_in(mclk), .addr_in(st_addr), .wdata_in(st_wdat), .we_in(st_we),
    .re_in(st_re), .rdata_out(st_rdata)
  );

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // busy is combinational, so it is only looked at 1 ns after an edge
  task automatic wait_idle;
    int n;
    n = 0;
    #1;
    while (busy && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic io_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_wr <= 1'b1;
    io_wdata <= d;
    @(posedge mclk);
    io_wr <= 1'b0;
    #1;
  endtask

  task automatic io_look(input logic [5:0] a);
    @(posedge mclk);
    io_addr <= a;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic do_op(input csic_op_t o, input logic [15:0] pc, input logic [7:0] d);
    @(posedge mclk);
    op_in <= o;
    pc_in <= pc;
    push_data <= d;
    @(posedge mclk);
    op_in <= OP_NONE;
    wait_idle();
  endtask

  task automatic ret_op(input csic_op_t o, input logic [15:0] pc);
    pc_q.push_back(pc);
    do_op(o, 16'h0000, 8'h00);
  endtask

  task automatic take(input logic [15:0] vec, input logic [15:0] pc);
    pc_q.push_back(vec);
    @(posedge mclk);
    pc_in <= pc;
    ins_end <= 1'b1;
    @(posedge mclk);
    ins_end <= 1'b0;
    #1;
    check("ack_onehot", {8'h00, ack}, 16'h0001 << (vec - 16'h0001));
    check("fetch_busy", {15'h0000, fetch_en}, 16'h0000);
    wait_idle();
  endtask

  // instruction boundary with optional enable set or clear, expecting no service
  task automatic step(input logic s, input logic c);
    @(posedge mclk);
    ins_end <= 1'b1;
    gie_set <= s;
    gie_clr <= c;
    @(posedge mclk);
    ins_end <= 1'b0;
    gie_set <= 1'b0;
    gie_clr <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
  endtask

  task automatic fire(input logic [7:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 8'h00;
    #1;
  endtask

  always @(negedge mclk)
  begin
    if (pc_load)
      check("pc_target", pc_tgt, (pc_q.size() > 0) ? pc_q.pop_front() : 16'hFFFF);
    if (alu_done)
      check("alu", {8'h00, alu_res}, (alu_q.size() > 0) ? {8'h00, alu_q.pop_front()} : 16'hFFFF);
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_sim();
  end

  initial
  begin
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] pa;
    logic [15:0] pb;
    csic_alu_t   o;
    void'($urandom(32'h3F76));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check("sp_reset", sp, STACK_PTR_RESET);
    check("gie_reset", {15'h0000, gie}, 16'h0000);
    check("fetch_idle", {15'h0000, fetch_en}, 16'h0001);
    io_write(STACK_PTR_HIGH_OFS, 8'h01);
    io_write(STACK_PTR_LOW_OFS, 8'hFF);
    check("sp_write", sp, 16'h01FF);
    io_look(STACK_PTR_HIGH_OFS);
    check("sph_read", {8'h00, io_rdata}, 16'h0001);
    io_look(6'h3F);
    check("unmapped", {8'h00, io_rdata}, 16'h0000);
    b = 8'($urandom);
    do_op(OP_PUSH, 16'h0000, b);
    check("sp_push", sp, 16'h01FE);
    check("push_byte", {8'h00, csic_stack_mem_i.mem[16'h01FF]}, {8'h00, b});
    do_op(OP_POP, 16'h0000, 8'h00);
    check("sp_pop", sp, 16'h01FF);
    pa = 16'($urandom_range(16'h0FFF, 16'h0100));
    do_op(OP_CALL, pa, 8'h00);
    check("sp_call", sp, 16'h01FD);
    check("ret_addr", {csic_stack_mem_i.mem[16'h01FE], csic_stack_mem_i.mem[16'h01FF]}, pa);
    ret_op(OP_RET, pa);
    check("sp_ret", sp, 16'h01FF);
    repeat (8)
    begin
      a = 8'($urandom);
      b = 8'($urandom);
      o = csic_alu_t'($urandom_range(3, 0));
      @(posedge mclk);
      alu_v <= 1'b1;
      alu_a <= a;
      alu_b <= b;
      alu_op <= o;
      alu_q.push_back(o == ALU_ADD ? a + b : o == ALU_SUB ? a - b : o == ALU_AND ? a & b : a | b);
    end
    @(posedge mclk);
    alu_v <= 1'b0;
    ena <= 8'h96;
    fire(8'h04);
    check("flag_held", {8'h00, flags}, 16'h0004);
    step(1'b1, 1'b0);
    pa = 16'($urandom_range(16'h0FFF, 16'h0100));
    take(16'h0003, pa);
    check("gie_entry", {15'h0000, gie}, 16'h0000);
    check("flag_acked", {8'h00, flags}, 16'h0000);
    check("sp_entry", sp, 16'h01FD);
    fire(8'h12);
    step(1'b0, 1'b0);
    check("flags_kept", {8'h00, flags}, 16'h0012);
    step(1'b1, 1'b0);
    pb = 16'($urandom_range(16'h0FFF, 16'h0100));
    take(16'h0002, pb);
    check("sp_nest", sp, 16'h01FB);
    ret_op(OP_RETURN_FROM_IRQ, pb);
    check("gie_return_from_irq", {15'h0000, gie}, 16'h0001);
    check("sp_return_from_irq", sp, 16'h01FD);
    take(16'h0005, pb);
    ret_op(OP_RETURN_FROM_IRQ, pb);
    ret_op(OP_RETURN_FROM_IRQ, pa);
    check("sp_back", sp, 16'h01FF);
    fire(8'h02);
    step(1'b0, 1'b1);
    check("gie_cli", {15'h0000, gie}, 16'h0000);
    @(posedge mclk);
    w1c <= 8'h02;
    st_wr <= 1'b1;
    st_wdata <= 8'h80;
    @(posedge mclk);
    w1c <= 8'h00;
    st_wr <= 1'b0;
    ena <= 8'h16;
    lvl <= 8'h80;
    #1;
    check("flag_w1c", {8'h00, flags}, 16'h0000);
    check("gie_status", {15'h0000, gie}, 16'h0001);
    step(1'b0, 1'b0);
    @(posedge mclk);
    lvl <= 8'h00;
    ena <= 8'h96;
    step(1'b0, 1'b0);
    pc_q.push_back(16'h0008);
    @(posedge mclk);
    pc_in <= pa;
    lvl <= 8'h80;
    sleep <= 1'b1;
    @(posedge mclk);
    wait_idle();
    @(posedge mclk);
    lvl <= 8'h00;
    sleep <= 1'b0;
    ret_op(OP_RETURN_FROM_IRQ, pa);
    check("pc_queue", 16'(pc_q.size()), 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire

// ---- bench/csic_stack_mem.sv ----
`default_nettype none
module csic_stack_mem
(
  input  wire logic        clk_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        we_in,
  input  wire logic        re_in,
  output logic      [7:0]  rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  always @(posedge clk_in)
  begin
    if (we_in)
      mem[addr_in] <= wdata_in;
  end
  // read data holds for one cycle only; a toggling pattern stops stale reuse
  always @(posedge clk_in)
  begin
    rdata_out <= re_in ? mem[addr_in] : ~rdata_out;
  end
endmodule
`default_nettype wire

// ---- hdl/csic_core.sv ----
`default_nettype none
module csic_core
  import csic_pkg::*;
#(
  parameter int                   NUM_SRC    = 8,
  parameter int                   SP_WIDTH   = 16,
  parameter logic [NUM_SRC-1:0]   LEVEL_MASK = '0
)
(
  input  wire logic               MCLK_IN,
  input  wire logic               RST_IN,
  input  wire logic [5:0]         IO_ADDR_IN,
  input  wire logic               IO_WR_IN,
  input  wire logic [7:0]         IO_WDATA_IN,
  output logic      [7:0]         IO_RDATA_OUT,
  input  wire csic_op_t           OP_IN,
  input  wire logic [7:0]         PUSH_DATA_IN,
  input  wire logic [15:0]        PC_IN,
  input  wire logic               INSTR_END_IN,
  input  wire logic               SLEEP_IN,
  input  wire logic               GIE_SET_IN,
  input  wire logic               GIE_CLR_IN,
  input  wire logic               STATUS_WR_IN,
  input  wire logic [7:0]         STATUS_WDATA_IN,
  input  wire logic [NUM_SRC-1:0] IRQ_EVENT_IN,
  input  wire logic [NUM_SRC-1:0] IRQ_LEVEL_IN,
  input  wire logic [NUM_SRC-1:0] IRQ_ENABLE_IN,
  input  wire logic [NUM_SRC-1:0] IRQ_FLAG_CLR_IN,
  input  wire logic               ALU_VALID_IN,
  input  wire csic_alu_t          ALU_OP_IN,
  input  wire logic [7:0]         ALU_A_IN,
  input  wire logic [7:0]         ALU_B_IN,
  input  wire logic [7:0]         STACK_RDATA_IN,
  output logic      [15:0]        STACK_ADDR_OUT,
  output logic      [7:0]         STACK_WDATA_OUT,
  output logic                    STACK_WE_OUT,
  output logic                    STACK_RE_OUT,
  output logic      [15:0]        SP_OUT,
  output logic                    GIE_OUT,
  output logic      [NUM_SRC-1:0] IRQ_FLAGS_OUT,
  output logic      [NUM_SRC-1:0] IRQ_ACK_OUT,
  output logic                    PC_LOAD_OUT,
  output logic      [15:0]        PC_TARGET_OUT,
  output logic                    BUSY_OUT,
  output logic                    FETCH_EN_OUT,
  output logic      [7:0]         ALU_RESULT_OUT,
  output logic                    ALU_DONE_OUT
);

  csic_state_t          state_reg;
  logic [SP_WIDTH-1:0]  sp_reg;
  logic [15:0]          sp_wide;
  logic [15:0]          sp_next;
  logic                 gie_reg;
  logic                 is_irq_reg;
  logic                 is_return_from_irq_reg;
  logic [2:0]           wait_reg;
  logic [15:0]          ret_addr_reg;
  logic [15:0]          vec_reg;
  logic [7:0]           hi_reg;
  logic [NUM_SRC-1:0]   req;
  logic [NUM_SRC-1:0]   sel_oh;
  logic [15:0]          sel_vec;
  logic [NUM_SRC-1:0]   ack_reg;
  logic                 take;
  logic                 idle_op;

  assign sp_wide = 16'(sp_reg);

  // per-source pending logic
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : src
      csic_irq_src #(.LEVEL_TYPE(LEVEL_MASK[g])) u_src
      (
        .clk_in      (MCLK_IN),
        .rst_in      (RST_IN),
        .event_in    (IRQ_EVENT_IN[g]),
        .level_in    (IRQ_LEVEL_IN[g]),
        .enable_in   (IRQ_ENABLE_IN[g]),
        .w1c_in      (IRQ_FLAG_CLR_IN[g]),
        .ack_in      (take & sel_oh[g]),
        .request_out (req[g]),
        .flag_out    (IRQ_FLAGS_OUT[g])
      );
    end
  endgenerate

  // lowest index holds the lowest vector and so the highest priority
  always_comb
  begin
    sel_oh  = '0;
    sel_vec = RESET_VECTOR;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        sel_oh  = NUM_SRC'(1) << i;
        sel_vec = FIRST_IRQ_VECTOR + 16'(i);
      end
    end
  end

  // gie_reg is the registered flag, so the boundary that ends an enable
  // or a return never services; the next instruction always runs first
  assign idle_op = (state_reg == ST_IDLE) && (OP_IN == OP_NONE);
  assign take    = idle_op && gie_reg && !GIE_CLR_IN && (|req)
                   && (INSTR_END_IN || SLEEP_IN);

  // stack pointer: i/o writes win over a stack adjustment in the same cycle
  always_comb
  begin
    sp_next = sp_wide;
    if (IO_WR_IN && IO_ADDR_IN == STACK_PTR_LOW_OFS)
      sp_next = {sp_wide[15:8], IO_WDATA_IN};
    else if (IO_WR_IN && IO_ADDR_IN == STACK_PTR_HIGH_OFS)
      sp_next = {IO_WDATA_IN, sp_wide[7:0]};
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (OP_IN == OP_PUSH)
            sp_next = sp_wide - 16'h0001;
          else if (OP_IN == OP_POP)
            sp_next = sp_wide + 16'h0001;
        end
        ST_PUSH_LO, ST_PUSH_HI:
          sp_next = sp_wide - 16'h0001;
        ST_POP_HI, ST_POP_LO:
          sp_next = sp_wide + 16'h0001;
        default:
          sp_next = sp_wide;
      endcase
    end
  end

  // truncation drops the absent high byte on narrow data spaces
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      sp_reg <= SP_WIDTH'(STACK_PTR_RESET);
    else
      sp_reg <= sp_next[SP_WIDTH-1:0];
  end

  // sequencer: only the return address is stacked, flags stay untouched
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      state_reg   <= ST_IDLE;
      is_irq_reg  <= 1'b0;
      is_return_from_irq_reg <= 1'b0;
      wait_reg    <= 3'h0;
      ret_addr_reg <= 16'h0000;
      vec_reg     <= RESET_VECTOR;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (take)
          begin
            state_reg    <= ST_PUSH_LO;
            is_irq_reg   <= 1'b1;
            ret_addr_reg <= PC_IN;
            vec_reg      <= sel_vec;
            wait_reg     <= SLEEP_IN ? SLEEP_EXTRA_CYCLES : 3'h0;
          end
          else if (OP_IN == OP_CALL)
          begin
            state_reg    <= ST_PUSH_LO;
            is_irq_reg   <= 1'b0;
            ret_addr_reg <= PC_IN;
          end
          else if (OP_IN == OP_RET || OP_IN == OP_RETURN_FROM_IRQ)
          begin
            state_reg   <= ST_POP_HI;
            is_return_from_irq_reg <= (OP_IN == OP_RETURN_FROM_IRQ);
          end
        end
        ST_PUSH_LO:
          state_reg <= ST_PUSH_HI;
        ST_PUSH_HI:
          state_reg <= is_irq_reg ? ST_ENT_WAIT : ST_IDLE;
        ST_ENT_WAIT:
        begin
          if (wait_reg == 3'h0)
            state_reg <= ST_ENT_VEC;
          else
            wait_reg <= wait_reg - 3'h1;
        end
        ST_ENT_VEC:
          state_reg <= ST_IDLE;
        ST_POP_HI:
          state_reg <= ST_POP_LO;
        ST_POP_LO:
          state_reg <= ST_RET_CAP;
        ST_RET_CAP:
          state_reg <= ST_RET_END;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // global enable: entry and clear win over return, status write and set paths
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      gie_reg <= GIE_RESET;
    else if (take)
      gie_reg <= 1'b0;
    else if (GIE_CLR_IN)
      gie_reg <= 1'b0;
    else if (state_reg == ST_RET_END && is_return_from_irq_reg)
      gie_reg <= 1'b1;
    else if (STATUS_WR_IN)
      gie_reg <= STATUS_WDATA_IN[GIE_BIT];
    else if (GIE_SET_IN)
      gie_reg <= 1'b1;
  end

  // registered stack memory port; read data arrive one cycle after the port
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      STACK_ADDR_OUT  <= 16'h0000;
      STACK_WDATA_OUT <= 8'h00;
      STACK_WE_OUT    <= 1'b0;
      STACK_RE_OUT    <= 1'b0;
    end
    else
    begin
      STACK_WE_OUT <= 1'b0;
      STACK_RE_OUT <= 1'b0;
      // a push stores at the current top; pops and returns read one above it
      if ((state_reg == ST_IDLE && OP_IN != OP_POP)
          || state_reg == ST_PUSH_LO || state_reg == ST_PUSH_HI)
        STACK_ADDR_OUT <= sp_wide;
      else
        STACK_ADDR_OUT <= sp_wide + 16'h0001;
      case (state_reg)
        ST_IDLE:
        begin
          STACK_WE_OUT    <= (OP_IN == OP_PUSH);
          STACK_RE_OUT    <= (OP_IN == OP_POP);
          STACK_WDATA_OUT <= PUSH_DATA_IN;
        end
        ST_PUSH_LO:
        begin
          STACK_WE_OUT    <= 1'b1;
          STACK_WDATA_OUT <= ret_addr_reg[7:0];
        end
        ST_PUSH_HI:
        begin
          STACK_WE_OUT    <= 1'b1;
          STACK_WDATA_OUT <= ret_addr_reg[15:8];
        end
        ST_POP_HI, ST_POP_LO:
          STACK_RE_OUT <= 1'b1;
        default:
          STACK_WDATA_OUT <= STACK_WDATA_OUT;
      endcase
    end
  end

  // program counter hand-back to the fetch unit
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      hi_reg        <= 8'h00;
      PC_LOAD_OUT   <= 1'b0;
      PC_TARGET_OUT <= RESET_VECTOR;
    end
    else
    begin
      PC_LOAD_OUT <= 1'b0;
      if (state_reg == ST_RET_CAP)
        hi_reg <= STACK_RDATA_IN;
      if (state_reg == ST_RET_END)
      begin
        PC_LOAD_OUT   <= 1'b1;
        PC_TARGET_OUT <= {hi_reg, STACK_RDATA_IN};
      end
      else if (state_reg == ST_ENT_VEC)
      begin
        PC_LOAD_OUT   <= 1'b1;
        PC_TARGET_OUT <= vec_reg;
      end
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      ack_reg <= '0;
    else
      ack_reg <= take ? sel_oh : '0;
  end

  // pointer readback: one cycle latency, unmapped and absent bytes read zero
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      IO_RDATA_OUT <= 8'h00;
    else if (IO_ADDR_IN == STACK_PTR_LOW_OFS)
      IO_RDATA_OUT <= sp_wide[7:0];
    else if (IO_ADDR_IN == STACK_PTR_HIGH_OFS)
      IO_RDATA_OUT <= sp_wide[15:8];
    else
      IO_RDATA_OUT <= 8'h00;
  end

  // two-operand alu result is registered one cycle after the operands are presented
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      ALU_RESULT_OUT <= 8'h00;
      ALU_DONE_OUT   <= 1'b0;
    end
    else
    begin
      ALU_DONE_OUT <= ALU_VALID_IN;
      if (ALU_VALID_IN)
      begin
        case (ALU_OP_IN)
          ALU_ADD: ALU_RESULT_OUT <= ALU_A_IN + ALU_B_IN;
          ALU_SUB: ALU_RESULT_OUT <= ALU_A_IN - ALU_B_IN;
          ALU_AND: ALU_RESULT_OUT <= ALU_A_IN & ALU_B_IN;
          default: ALU_RESULT_OUT <= ALU_A_IN | ALU_B_IN;
        endcase
      end
    end
  end

  // core clock drives everything directly; no divider, no enables
  assign FETCH_EN_OUT = (state_reg == ST_IDLE);
  assign BUSY_OUT     = (state_reg != ST_IDLE);
  assign SP_OUT       = sp_wide;
  assign GIE_OUT      = gie_reg;
  assign IRQ_ACK_OUT  = ack_reg;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  sequence entry_steps;
    state_reg == ST_PUSH_LO ##1 state_reg == ST_PUSH_HI ##1 state_reg == ST_ENT_WAIT;
  endsequence

  sequence return_steps;
    state_reg == ST_POP_HI ##1 state_reg == ST_POP_LO ##1 state_reg == ST_RET_CAP
      ##1 state_reg == ST_RET_END;
  endsequence

  chk_sp_after_reset: assert property ($past(RST_IN) |-> SP_OUT == STACK_PTR_RESET)
    else $error("stack pointer not zero after reset");
  chk_push_lowers_sp: assert property (idle_op == 1'b0 && state_reg == ST_IDLE && OP_IN == OP_PUSH
    && !IO_WR_IN |=> sp_reg == $past(sp_reg) - SP_WIDTH'(1))
    else $error("push did not lower pointer by one");
  chk_pop_raises_sp: assert property (state_reg == ST_IDLE && OP_IN == OP_POP && !IO_WR_IN
    |=> sp_reg == $past(sp_reg) + SP_WIDTH'(1))
    else $error("pop did not raise pointer by one");
  chk_call_lowers_two: assert property (state_reg == ST_PUSH_LO && !IO_WR_IN ##1 !IO_WR_IN
    |=> sp_reg == $past(sp_reg, 2) - SP_WIDTH'(2))
    else $error("call or entry did not lower pointer by two");
  chk_ret_raises_two: assert property (state_reg == ST_POP_HI && !IO_WR_IN ##1 !IO_WR_IN
    |=> sp_reg == $past(sp_reg, 2) + SP_WIDTH'(2))
    else $error("return did not raise pointer by two");
  chk_take_enabled: assert property (take |-> gie_reg
    && (|((IRQ_FLAGS_OUT | (IRQ_LEVEL_IN & LEVEL_MASK)) & IRQ_ENABLE_IN)))
    else $error("interrupt taken while disabled");
  chk_take_priority: assert property (take |-> (req & (sel_oh - NUM_SRC'(1))) == '0)
    else $error("lower priority source won");
  chk_entry_gie_off: assert property (take |=> !gie_reg ##1 !gie_reg)
    else $error("global enable still set after entry");
  chk_return_from_irq_sets_gie: assert property (state_reg == ST_RET_END && is_return_from_irq_reg |=> gie_reg)
    else $error("interrupt return left global enable clear");
  chk_cli_blocks: assert property (GIE_CLR_IN |-> !take ##1 !take)
    else $error("interrupt taken despite global disable");
  chk_entry_length: assert property (take && !SLEEP_IN |=> entry_steps ##1
    state_reg == ST_ENT_VEC ##1 PC_LOAD_OUT)
    else $error("interrupt entry not four cycles");
  chk_return_length: assert property (state_reg == ST_IDLE && OP_IN == OP_RETURN_FROM_IRQ
    |=> return_steps ##1 PC_LOAD_OUT && gie_reg)
    else $error("interrupt return not four cycles");
  chk_ack_follows: assert property (take |=> IRQ_ACK_OUT == $past(sel_oh))
    else $error("taken source not acknowledged");
  chk_alu_one_cycle: assert property (ALU_VALID_IN |=> ALU_DONE_OUT)
    else $error("alu result late");

endmodule
`default_nettype wire

// ---- hdl/csic_irq_src.sv ----
`default_nettype none
module csic_irq_src
  import csic_pkg::*;
#(
  parameter bit LEVEL_TYPE = 1'b0
)
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic event_in,
  input  wire logic level_in,
  input  wire logic enable_in,
  input  wire logic w1c_in,
  input  wire logic ack_in,
  output logic      request_out,
  output logic      flag_out
);

  logic flag_reg;

  // a new event beats a clear in the same cycle, so none is lost
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      flag_reg <= 1'b0;
    else if (event_in && !LEVEL_TYPE)
      flag_reg <= 1'b1;
    else if (w1c_in || ack_in)
      flag_reg <= 1'b0;
  end

  // level sources keep no memory: a vanished condition asks for nothing
  assign request_out = LEVEL_TYPE ? (level_in & enable_in) : (flag_reg & enable_in);
  assign flag_out    = LEVEL_TYPE ? 1'b0 : flag_reg;

endmodule
`default_nettype wire

// ---- hdl/csic_pkg.sv ----
`default_nettype none
package csic_pkg;

  // i/o space offsets of the stack pointer bytes
  localparam logic [5:0]  STACK_PTR_LOW_OFS   = 6'h3D;
  localparam logic [5:0]  STACK_PTR_HIGH_OFS  = 6'h3E;
  localparam logic [15:0] STACK_PTR_RESET     = 16'h0000;

  // global enable position inside the cpu flags register
  localparam int          GIE_BIT             = 7;
  localparam logic        GIE_RESET           = 1'b0;

  // reset owns the lowest vector, sources follow in priority order
  localparam logic [15:0] RESET_VECTOR        = 16'h0000;
  localparam logic [15:0] FIRST_IRQ_VECTOR    = 16'h0001;

  // cycle counts of the entry and return sequences
  localparam int          ENTRY_CYCLES        = 4;
  localparam int          RETURN_CYCLES       = 4;
  localparam logic [2:0]  SLEEP_EXTRA_CYCLES  = 3'h4;

  typedef enum logic [2:0]
  {
    OP_NONE = 3'h0,
    OP_PUSH = 3'h1,
    OP_POP  = 3'h2,
    OP_CALL = 3'h3,
    OP_RET  = 3'h4,
    OP_RETURN_FROM_IRQ = 3'h5
  } csic_op_t;

  typedef enum logic [3:0]
  {
    ST_IDLE     = 4'h0,
    ST_PUSH_LO  = 4'h1,
    ST_PUSH_HI  = 4'h2,
    ST_ENT_WAIT = 4'h3,
    ST_ENT_VEC  = 4'h4,
    ST_POP_HI   = 4'h5,
    ST_POP_LO   = 4'h6,
    ST_RET_CAP  = 4'h7,
    ST_RET_END  = 4'h8
  } csic_state_t;

  typedef enum logic [1:0]
  {
    ALU_ADD = 2'h0,
    ALU_SUB = 2'h1,
    ALU_AND = 2'h2,
    ALU_OR  = 2'h3
  } csic_alu_t;

endpackage
`default_nettype wire
